// >>> rtl/bie_buffer_irq.sv
// Buffer interrupt enables, buffer event flags and the two wrap counters.
// Assumes event inputs are one-cycle pulses synchronous to clk.
//
// Functional notes
// - Low six config bits read fixed 001011.
// - Config bits 7-13 and 15 each enable one event interrupt.
// - Soft request bit fires once per one-write.
// - DMA done enable raises irq, sets flag.
// - Transmit space enable raises irq on ready.
// - Underrun sets flag bit 9, frame dropped.
// - Lost frame sets flag bit A, interrupts.
// - Early receive irq after 128 bytes.
// - Collision counter 1FF to 200 interrupts.
// - Collision counter counts collisions during transmit.
// - Miss counter 1FF to 200 interrupts.
// - Each miss sets flag and counts.
// - Destination match irq precedes early receive.
// - Event switches dest match to early at 128.
// - Reset default, optional EEPROM load value.
// - Enable bit positions fixed as mapped.
// - Event flags clear on read.
// - Ten-bit miss count wraps, clears on read.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "bie_map.svh"

module bie_buffer_irq
    import bie_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Initial value from EEPROM
    input wire logic eepromLoad,
    input wire logic [9:0] eepromCfg,
    // Buffer events
    input wire logic rxDmaDone,
    input wire logic txSpaceReady,
    input wire logic txStarve,
    input wire logic lostFrame,
    input wire logic destMatch,
    input wire logic rxByte128,
    input wire logic transmitting,
    input wire logic collisionSeen,
    // Interrupt request
    output logic irq,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [9:0] enable, next_enable;
    logic [9:0] flags, next_flags;
    logic [9:0] missCount, next_missCount;
    logic [9:0] colCount, next_colCount;
    logic irqHold, next_irqHold;
    logic collPrev, next_collPrev;
    logic loaded, next_loaded;
    logic awHeld, next_awHeld;
    logic wHeld, next_wHeld;
    logic [ADDR_W-1:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic bValid, next_bValid;
    logic [1:0] bResp, next_bResp;
    bie_rd_state_t rdState, next_rdState;
    logic [31:0] rData, next_rData;
    logic [1:0] rResp, next_rResp;
    logic awRdy, next_awRdy;
    logic wRdy, next_wRdy;
    logic arRdy, next_arRdy;
    logic rValid, next_rValid;

    // Event vector, enable bit i maps onto config bit i+6
    logic [9:0] ev;
    logic doWrite, doRead, cfgWrite, softKick;
    logic [ADDR_W-1:0] rdAddr;
    logic [15:0] cfgView;

    always_comb begin
        ev = `BIE_EVT_NONE;
        ev[`BIE_B_DMA-6] = rxDmaDone;
        ev[`BIE_B_TXSP-6] = txSpaceReady;
        ev[`BIE_B_STARVE-6] = txStarve;
        ev[`BIE_B_LOST-6] = lostFrame;
        ev[`BIE_B_EARLY-6] = rxByte128;
        ev[`BIE_B_COLW-6] = (colCount == `BIE_CNT_WARN) && transmitting
            && collisionSeen && !collPrev;
        ev[`BIE_B_LOSTW-6] = (missCount == `BIE_CNT_WARN) && lostFrame;
        ev[`BIE_B_DEST-6] = destMatch;
    end

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign doWrite = awHeld && wHeld && !bValid;
    assign cfgWrite = doWrite && (awAddr[ADDR_W-1:2] == `BIE_ADDR_CFG >> 2);
    // Act once: the bit is never stored, only pulses the event
    assign softKick = cfgWrite && wStrb[0] && wData[`BIE_B_SOFT];
    assign doRead = (rdState == BIE_RD_IDLE) && s_axi_arvalid && arRdy;
    assign rdAddr = s_axi_araddr;
    assign cfgView = {enable[9:1], 1'b0, `BIE_ID_CFG};

    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bValid = bValid;
        next_bResp = bResp;
        next_awRdy = !awHeld && !(s_axi_awvalid && awRdy);
        next_wRdy = !wHeld && !(s_axi_wvalid && wRdy);
        if (s_axi_awvalid && awRdy) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wRdy) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
            next_bValid = 1'b1;
            next_bResp = (awAddr[ADDR_W-1:2] == `BIE_ADDR_CFG >> 2) ? `BIE_RESP_OKAY
                : `BIE_RESP_SLVERR;
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_awRdy = 1'b0;
            next_wRdy = 1'b0;
        end
        if (bValid && s_axi_bready) begin
            next_bValid = 1'b0;
            next_awRdy = 1'b1;
            next_wRdy = 1'b1;
        end else if (bValid) begin
            next_awRdy = 1'b0;
            next_wRdy = 1'b0;
        end
    end

    // ----------------------------------------
    // Read path with clear-on-read side effects
    // ----------------------------------------
    logic clrFlags, clrMiss, clrCol;

    always_comb begin
        next_rdState = rdState;
        next_rData = rData;
        next_rResp = rResp;
        next_arRdy = arRdy;
        clrFlags = 1'b0;
        clrMiss = 1'b0;
        clrCol = 1'b0;
        case (rdState)
            BIE_RD_IDLE: begin
                next_arRdy = 1'b1;
                if (doRead) begin
                    next_rdState = BIE_RD_RESP;
                    next_arRdy = 1'b0;
                    next_rResp = `BIE_RESP_OKAY;
                    case (rdAddr[ADDR_W-1:2])
                        `BIE_ADDR_CFG >> 2: next_rData = {`BIE_HALF_ZERO, cfgView};
                        `BIE_ADDR_EVT >> 2: begin
                            next_rData = {`BIE_HALF_ZERO, flags, `BIE_ID_EVT};
                            clrFlags = 1'b1;
                        end
                        `BIE_ADDR_MISS >> 2: begin
                            next_rData = {`BIE_HALF_ZERO, missCount, `BIE_ID_MISS};
                            clrMiss = 1'b1;
                        end
                        `BIE_ADDR_COL >> 2: begin
                            next_rData = {`BIE_HALF_ZERO, colCount, `BIE_ID_COL};
                            clrCol = 1'b1;
                        end
                        default: begin
                            next_rData = `BIE_DATA_ZERO;
                            next_rResp = `BIE_RESP_SLVERR;
                        end
                    endcase
                end
            end
            BIE_RD_RESP: begin
                next_arRdy = 1'b0;
                if (s_axi_rready) begin
                    next_rdState = BIE_RD_IDLE;
                    next_arRdy = 1'b1;
                end
            end
            default: begin
                next_rdState = BIE_RD_IDLE;
                next_arRdy = 1'b0;
            end
        endcase
        next_rValid = (next_rdState == BIE_RD_RESP);
    end

    // ----------------------------------------
    // Enables, flags, counters, interrupt
    // ----------------------------------------
    logic [9:0] evAll;
    logic collEdge;

    always_comb begin
        evAll = ev;
        evAll[`BIE_B_SOFT-6] = softKick;
        collEdge = transmitting && collisionSeen && !collPrev;
        next_collPrev = collisionSeen;
        next_loaded = 1'b1;
        next_enable = enable;
        // Strap taken once at the first edge after release
        if (!loaded && eepromLoad) begin
            next_enable = eepromCfg;
        end
        // Lane 1 carries bits 15:8, lane 0 the DMA enable
        if (cfgWrite && wStrb[1]) begin
            next_enable[9:2] = wData[15:8];
        end
        if (cfgWrite && wStrb[0]) begin
            next_enable[1] = wData[`BIE_B_DMA];
        end
        // Set beats the clear-on-read in the same cycle
        next_flags = (clrFlags ? `BIE_EVT_NONE : flags) | evAll;
        // Early receive replaces the destination-match indication
        if (rxByte128) begin
            next_flags[`BIE_B_DEST-6] = 1'b0;
        end
        next_missCount = clrMiss ? `BIE_CNT_ZERO : missCount;
        if (lostFrame) begin
            next_missCount = next_missCount + `BIE_CNT_ONE;
        end
        next_colCount = clrCol ? `BIE_CNT_ZERO : colCount;
        if (collEdge) begin
            next_colCount = next_colCount + `BIE_CNT_ONE;
        end
        next_irqHold = |(next_flags & {next_enable[9:1], 1'b1});
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable <= `BIE_CFG_RESET;
            flags <= `BIE_EVT_NONE;
            missCount <= `BIE_CNT_ZERO;
            colCount <= `BIE_CNT_ZERO;
            irqHold <= 1'b0;
            collPrev <= 1'b0;
            loaded <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= `BIE_DATA_ZERO;
            wStrb <= 4'h0;
            bValid <= 1'b0;
            bResp <= `BIE_RESP_OKAY;
            rdState <= BIE_RD_IDLE;
            rData <= `BIE_DATA_ZERO;
            rResp <= `BIE_RESP_OKAY;
            awRdy <= 1'b0;
            wRdy <= 1'b0;
            arRdy <= 1'b0;
            rValid <= 1'b0;
        end else begin
            enable <= next_enable;
            flags <= next_flags;
            missCount <= next_missCount;
            colCount <= next_colCount;
            irqHold <= next_irqHold;
            collPrev <= next_collPrev;
            loaded <= next_loaded;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            bValid <= next_bValid;
            bResp <= next_bResp;
            rdState <= next_rdState;
            rData <= next_rData;
            rResp <= next_rResp;
            awRdy <= next_awRdy;
            wRdy <= next_wRdy;
            arRdy <= next_arRdy;
            rValid <= next_rValid;
        end
    end

    // ----------------------------------------
    // Outputs straight from flip-flops
    // ----------------------------------------
    assign irq = irqHold;
    assign s_axi_awready = awRdy;
    assign s_axi_wready = wRdy;
    assign s_axi_bvalid = bValid;
    assign s_axi_bresp = bResp;
    assign s_axi_arready = arRdy;
    assign s_axi_rvalid = rValid;
    assign s_axi_rdata = rData;
    assign s_axi_rresp = rResp;

endmodule

`default_nettype wire

// >>> rtl/bie_map.svh
// Register map, field positions and reset values of the buffer interrupt block.
// Assumes inclusion by bare name from rtl/.
`ifndef BIE_MAP_SVH
`define BIE_MAP_SVH

// ----------------------------------------
// Byte addresses (index times four)
// ----------------------------------------
`define BIE_IDX_CFG 12'h10a
`define BIE_IDX_EVT 12'h12c
`define BIE_IDX_MISS 12'h130
`define BIE_IDX_COL 12'h132
`define BIE_ADDR_CFG 14'h0428
`define BIE_ADDR_EVT 14'h04b0
`define BIE_ADDR_MISS 14'h04c0
`define BIE_ADDR_COL 14'h04c8

// ----------------------------------------
// Fixed identifier patterns, low six bits
// ----------------------------------------
`define BIE_ID_CFG 6'h0b
`define BIE_ID_EVT 6'h0c
`define BIE_ID_MISS 6'h10
`define BIE_ID_COL 6'h12

// ----------------------------------------
// Bit positions
// ----------------------------------------
`define BIE_B_SOFT 6
`define BIE_B_DMA 7
`define BIE_B_TXSP 8
`define BIE_B_STARVE 9
`define BIE_B_LOST 10
`define BIE_B_EARLY 11
`define BIE_B_COLW 12
`define BIE_B_LOSTW 13
`define BIE_B_DEST 15

// ----------------------------------------
// Values
// ----------------------------------------
`define BIE_CFG_RESET 10'h000
`define BIE_CNT_ZERO 10'h000
`define BIE_CNT_ONE 10'h001
`define BIE_CNT_WARN 10'h1ff
`define BIE_EVT_MASK 10'h3ff
`define BIE_EVT_NONE 10'h000
`define BIE_RESP_OKAY 2'h0
`define BIE_RESP_SLVERR 2'h2
`define BIE_DATA_ZERO 32'h0000_0000
`define BIE_HALF_ZERO 16'h0000

`endif

// >>> rtl/bie_pkg.sv
// Types shared by the buffer interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package bie_pkg;
    typedef enum logic [1:0] {
        BIE_RD_IDLE,
        BIE_RD_RESP
    } bie_rd_state_t;
endpackage

// >>> tb/bie_buffer_irq_sva.sv
// Bus and interrupt assertions for the buffer interrupt block.
// Assumes binding to bie_buffer_irq with its register map header.
`timescale 1ns/10ps
`default_nettype none
`include "bie_map.svh"
module bie_buffer_irq_sva
    import bie_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Events
    input wire logic rxDmaDone,
    input wire logic txSpaceReady,
    input wire logic txStarve,
    input wire logic lostFrame,
    input wire logic destMatch,
    input wire logic rxByte128,
    input wire logic collisionSeen,
    input wire logic irq,
    // Bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic [ADDR_W-1:0] rdAddr;
    logic cause;
    logic wrBoth;
    assign wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign cause = rxDmaDone | txSpaceReady | txStarve | lostFrame | destMatch | rxByte128
        | collisionSeen | (s_axi_wvalid && s_axi_wready);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdAddr <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rdAddr <= s_axi_araddr;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_rdHold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rdHold: assert property (p_rdHold) else $error("read data dropped early");
    property p_wrHold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_wrHold: assert property (p_wrHold) else $error("write response dropped early");
    property p_rdLat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rdLat: assert property (p_rdLat) else $error("read answer late");
    property p_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_busy: assert property (p_busy) else $error("ready while response pends");
    property p_cfgId;
        s_axi_rvalid && rdAddr == `BIE_ADDR_CFG |-> s_axi_rdata[6:0] == 7'h0b;
    endproperty
    a_cfgId: assert property (p_cfgId) else $error("config low bits wrong");
    property p_cntId;
        s_axi_rvalid && rdAddr == `BIE_ADDR_MISS |-> s_axi_rdata[5:0] == 6'h10;
    endproperty
    a_cntId: assert property (p_cntId) else $error("miss counter low bits wrong");
    property p_slvErr;
        s_axi_rvalid && !(rdAddr inside {`BIE_ADDR_CFG, `BIE_ADDR_EVT, `BIE_ADDR_MISS,
            `BIE_ADDR_COL}) |-> s_axi_rresp == `BIE_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_slvErr: assert property (p_slvErr) else $error("unmapped read not refused");
    property p_soft;
        wrBoth && s_axi_awaddr == `BIE_ADDR_CFG && s_axi_wstrb[0] && s_axi_wdata[6]
            |-> ##[1:3] irq;
    endproperty
    a_soft: assert property (p_soft) else $error("soft request gave no irq");
    property p_irqCause;
        $rose(irq) |-> $past(cause) || $past(cause, 2) || $past(cause, 3);
    endproperty
    a_irqCause: assert property (p_irqCause) else $error("irq without cause");
endmodule
bind bie_buffer_irq bie_buffer_irq_sva #(.ADDR_W(ADDR_W)) i_bie_buffer_irq_sva (.clk, .arst_n,
    .rxDmaDone, .txSpaceReady, .txStarve, .lostFrame, .destMatch, .rxByte128, .collisionSeen,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// >>> tb/bie_buffer_irq_tb.sv
// Self-checking bench for the buffer interrupt block.
// Assumes the design and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "bie_map.svh"
module bie_buffer_irq_tb;
    logic clk = '0, arst_n = '0, eepromLoad = '0, transmitting = '0, collisionSeen = '0;
    logic [9:0] eepromCfg = '0;
    logic [5:0] ev = '0;
    logic rxDmaDone, txSpaceReady, txStarve, lostFrame, rxByte128, destMatch, irq;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int numErrors = 0, checksDone = 0, cyc = 0;
    assign {destMatch, rxByte128, lostFrame, txStarve, txSpaceReady, rxDmaDone} = ev;
    bie_buffer_irq i_bie_buffer_irq (
        .clk(clk), .arst_n(arst_n), .eepromLoad(eepromLoad), .eepromCfg(eepromCfg),
        .rxDmaDone(rxDmaDone), .txSpaceReady(txSpaceReady), .txStarve(txStarve),
        .lostFrame(lostFrame), .destMatch(destMatch), .rxByte128(rxByte128),
        .transmitting(transmitting), .collisionSeen(collisionSeen), .irq(irq),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );
    always #12.5 clk = ~clk;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input logic [31:0] g, input logic [31:0] e);
        checksDone++;
        if (g !== e) begin
            numErrors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
        bit fa, fw;
        fa = 0;
        fw = 0;
        // Let an edge pass so bready is never driven twice in one step
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(fa && fw)) begin
            @(posedge clk);
            if (s_axi_awready) begin
                fa = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wready) begin
                fw = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, r);
    endtask
    task rd(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
    endtask
    task irqIs(input logic e);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task pulse(input int i);
        ev[i] <= 1'h1;
        @(posedge clk);
        ev <= '0;
        repeat (2) @(posedge clk);
    endtask
    task tog;
        collisionSeen <= 1'h1;
        @(posedge clk);
        collisionSeen <= 1'h0;
        @(posedge clk);
    endtask
    task conclude;
        $display("checks %0d errors %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_soft;
        rd(`BIE_ADDR_CFG, 32'h0b);
        wr(`BIE_ADDR_CFG, 32'hbfff, 2'h0);
        irqIs(1'h1);
        rd(`BIE_ADDR_CFG, 32'hbf8b);
        rd(`BIE_ADDR_EVT, 32'h4c);
        irqIs(1'h0);
        wr(`BIE_ADDR_CFG, 32'hbfbf, 2'h0);
        irqIs(1'h0);
        $display("soft done");
    endtask
    task t_events;
        int bp[6] = '{7, 8, 9, 10, 11, 15};
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            irqIs(1'h1);
            rd(`BIE_ADDR_EVT, (32'h1 << bp[i]) | 32'hc);
            irqIs(1'h0);
        end
        rd(`BIE_ADDR_MISS, 32'h50);
        rd(`BIE_ADDR_MISS, 32'h10);
        wr(`BIE_ADDR_CFG, 32'h0, 2'h0);
        pulse(0);
        irqIs(1'h0);
        rd(`BIE_ADDR_EVT, 32'h8c);
        wr(`BIE_ADDR_CFG, 32'hbf80, 2'h0);
        pulse(5);
        pulse(4);
        rd(`BIE_ADDR_EVT, 32'h80c);
        pulse(2);
        pulse(1);
        rd(`BIE_ADDR_EVT, 32'h30c);
        $display("events done");
    endtask
    task t_wrap;
        repeat (3) tog;
        transmitting <= 1'h1;
        repeat (512) tog;
        transmitting <= 1'h0;
        irqIs(1'h1);
        rd(`BIE_ADDR_COL, 32'h8012);
        rd(`BIE_ADDR_EVT, 32'h100c);
        repeat (512) pulse(3);
        irqIs(1'h1);
        rd(`BIE_ADDR_MISS, 32'h8010);
        rd(`BIE_ADDR_EVT, 32'h240c);
        rd(`BIE_ADDR_MISS, 32'h10);
        $display("wrap done");
    endtask
    task t_misc;
        rd(14'h4, 32'h0, 2'h2);
        wr(14'h4, 32'hffff, 2'h2);
        rd(`BIE_ADDR_CFG, 32'hbf8b);
        arst_n <= 1'h0;
        eepromLoad <= 1'h1;
        eepromCfg <= 10'h203;
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        repeat (2) @(posedge clk);
        rd(`BIE_ADDR_CFG, 32'h808b);
        rd(`BIE_ADDR_EVT, 32'hc);
        $display("misc done");
    endtask
    // Hang guard: the run needs about 2800 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            numErrors++;
            conclude;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        repeat (2) @(posedge clk);
        t_soft;
        t_events;
        t_wrap;
        t_misc;
        conclude;
    end
endmodule
`default_nettype wire
